//--- rtl/stepper_phase_current_sequencer.sv
// Stepper phase current sequencer: steps, mode tables, current scaling and brake gating.
`timescale 1ns/10ps
// Summary of operation
// - Chopper at 20 kHz, restarted by steps
// - Full step energises both phases unless output disabled
// - Half step cycles phase1, both, phase2
// - Single phase in half step scaled sqrt2
// - Ministep subdivides half step by 2.5/5
// - Ministep currents follow sine approximation
// - Current_input_a raises current by thirty percent
// - Current_input_a controlled solely by current_input_a input
// - Full step above 1 kHz scales 1.4
// - Brake release input energises brake output
// - Reset, disable or fault keep brake off
// - Inputs active when optocoupler conducts
// - Switch 0-7 positive, 8-F inverted logic
// - 5 us pulse steps; 40 ms idle stops
// - Direction input active reverses stepping
// - Output disable switches motor current off
module stepper_phase_current_sequencer #(
   parameter int IDLE_LIMIT = stepper_seq_pkg::IDLE_CYCLES
) (
   // Clock and synchronous reset.
   input  wire logic        clk,
   input  wire logic        srst,
   // Opto-isolated inputs, conducting = 1 at the pin.
   input  wire logic        stepPin,
   input  wire logic        dirPin,
   input  wire logic        boostPin,
   input  wire logic        disablePin,
   input  wire logic        resetPin,
   input  wire logic        brakePin,
   // Configuration and fault status.
   input  wire logic [3:0]  inputPolaritySwitch,
   input  wire logic [1:0]  stepMode,
   input  wire logic        faultActive,
   // Phase current commands, sign and magnitude (unity 1024).
   output logic             phaseASign,
   output logic [12:0]      phaseAMag,
   output logic             phaseBSign,
   output logic [12:0]      phaseBMag,
   // Chopper sync pulse, run state, brake drive.
   output logic             chopSync,
   output logic             running,
   output logic             brakeOn
);
   // Two-stage synchronisers for the six pins.
   logic [5:0] syncA, syncB;
   // Inputs after polarity selection.
   logic [5:0] act;
   logic       inv;
   logic       stepIn, dirIn, boostIn, disIn, rstIn, brkIn;
   // Synchroniser registers; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA <= 6'h00;
         syncB <= 6'h00;
      end else begin
         syncA <= {brakePin, resetPin, disablePin, boostPin, dirPin, stepPin};
         syncB <= syncA;
      end
   end
   // Polarity switch chooses positive or inverted input logic.
   always_comb begin
      inv    = (inputPolaritySwitch >= stepper_seq_pkg::POL_INV_MIN);
      act    = inv ? ~syncB : syncB;
      stepIn = act[0];
      dirIn  = act[1];
      boostIn = act[2];
      disIn  = act[3];
      rstIn  = act[4];
      brkIn  = act[5];
   end
   // Pulse qualifier, position, timers.
   stepper_seq_pkg::pulse_state_type pState, next_pState;
   logic [11:0] pulseCnt, next_pulseCnt;
   logic [31:0] idleCnt, next_idleCnt;
   logic [31:0] periodCnt, next_periodCnt;
   logic        fast, next_fast;
   logic [5:0]  pos, next_pos;
   logic        next_running;
   logic [15:0] chopCnt, next_chopCnt;
   logic        stepEvt;
   logic [5:0]  cycleLen;
   // Positions in one electrical cycle for a mode.
   function automatic logic [5:0] cycle_len(input logic [1:0] m);
      case (m)
         stepper_seq_pkg::MODE_FULL:   cycle_len = stepper_seq_pkg::FULL_POS;
         stepper_seq_pkg::MODE_HALF:   cycle_len = stepper_seq_pkg::HALF_POS;
         stepper_seq_pkg::MODE_MINI25: cycle_len = stepper_seq_pkg::MINI25_POS;
         default:                      cycle_len = stepper_seq_pkg::MINI5_POS;
      endcase
   endfunction
   // Next-state logic for stepping and timing.
   always_comb begin
      next_pState    = pState;
      next_pulseCnt  = pulseCnt;
      stepEvt        = 1'b0;
      cycleLen       = cycle_len(stepMode);
      case (pState)
         stepper_seq_pkg::PULSE_IDLE: begin
            next_pulseCnt = 12'h000;
            if (stepIn) begin
               next_pState = stepper_seq_pkg::PULSE_HIGH;
            end
         end
         stepper_seq_pkg::PULSE_HIGH: begin
            // A pulse counts once it has lasted the least width.
            if (!stepIn) begin
               next_pState = stepper_seq_pkg::PULSE_IDLE;
            end else if (pulseCnt == 12'(stepper_seq_pkg::STEP_MIN_CYCLES - 2)) begin
               next_pState = stepper_seq_pkg::PULSE_DONE;
               stepEvt     = 1'b1;
            end else begin
               next_pulseCnt = pulseCnt + 12'h001;
            end
         end
         stepper_seq_pkg::PULSE_DONE: begin
            if (!stepIn) begin
               next_pState = stepper_seq_pkg::PULSE_IDLE;
            end
         end
         default: next_pState = stepper_seq_pkg::PULSE_IDLE;
      endcase
      // Position index moves per step, reversed by direction.
      next_pos = (pos >= cycleLen) ? 6'h00 : pos;
      if (stepEvt) begin
         if (dirIn) begin
            next_pos = (next_pos == 6'h00) ? cycleLen - 6'h01 : next_pos - 6'h01;
         end else begin
            next_pos = (next_pos == cycleLen - 6'h01) ? 6'h00 : next_pos + 6'h01;
         end
      end
      // Idle timer drops running back to zero.
      next_running = running;
      next_idleCnt = idleCnt;
      if (stepEvt) begin
         next_running = 1'b1;
         next_idleCnt = 32'h0000_0000;
      end else if (idleCnt >= 32'(IDLE_LIMIT)) begin
         next_running = 1'b0;
      end else begin
         next_idleCnt = idleCnt + 32'h0000_0001;
      end
      // Step period measurement for high_speed_current_scaling.
      next_fast      = fast;
      next_periodCnt = (periodCnt == 32'hFFFF_FFFF) ? periodCnt : periodCnt + 32'h0000_0001;
      if (stepEvt) begin
         next_fast      = (periodCnt < 32'(stepper_seq_pkg::OVD_PERIOD_CYC));
         next_periodCnt = 32'h0000_0000;
      end else if (periodCnt >= 32'(stepper_seq_pkg::OVD_PERIOD_CYC)) begin
         next_fast = 1'b0;
      end
      // Chopper counter restarts on each step to stay in sync.
      if (stepEvt || chopCnt == 16'(stepper_seq_pkg::CHOP_CYCLES - 1)) begin
         next_chopCnt = 16'h0000;
      end else begin
         next_chopCnt = chopCnt + 16'h0001;
      end
   end
   // Registers for stepping and timing.
   always_ff @(posedge clk) begin
      if (srst) begin
         pState    <= stepper_seq_pkg::PULSE_IDLE;
         pulseCnt  <= 12'h000;
         idleCnt   <= 32'h0000_0000;
         periodCnt <= 32'h0000_0000;
         fast      <= 1'b0;
         pos       <= 6'h00;
         running   <= 1'b0;
         chopCnt   <= 16'h0000;
      end else begin
         pState    <= next_pState;
         pulseCnt  <= next_pulseCnt;
         idleCnt   <= next_idleCnt;
         periodCnt <= next_periodCnt;
         fast      <= next_fast;
         pos       <= next_pos;
         running   <= next_running;
         chopCnt   <= next_chopCnt;
      end
   end
   // Sine table over one quarter, 10 ministeps, scaled to unity.
   function automatic logic [11:0] sine_q(input logic [3:0] k);
      case (k)
         4'h0: sine_q = 12'h000;
         4'h1: sine_q = 12'h0A0;
         4'h2: sine_q = 12'h13C;
         4'h3: sine_q = 12'h1D1;
         4'h4: sine_q = 12'h25A;
         4'h5: sine_q = 12'h2D4;
         4'h6: sine_q = 12'h33C;
         4'h7: sine_q = 12'h38E;
         4'h8: sine_q = 12'h3CD;
         4'h9: sine_q = 12'h3F3;
         default: sine_q = 12'h400;
      endcase
   endfunction
   // Shape, sign and scaling terms; the signs are the next sign outputs.
   logic [11:0] magA, magB;
   logic        sgnA, sgnB;
   logic [5:0]  angle, qpos;
   logic [1:0]  quad;
   logic [24:0] prodA, prodB;
   logic [11:0] gain;
   logic        next_chopSync, next_brakeOn;
   logic [12:0] next_magA, next_magB;
   // Phase current shape per mode, then scaling factors.
   always_comb begin
      magA  = 12'h000;
      magB  = 12'h000;
      sgnA  = 1'b0;
      sgnB  = 1'b0;
      angle = 6'h00;
      qpos  = 6'h00;
      quad  = 2'h0;
      case (stepMode)
         stepper_seq_pkg::MODE_FULL: begin
            // Both phases at unity; output disable later clears them.
            magA = stepper_seq_pkg::UNITY;
            magB = stepper_seq_pkg::UNITY;
            sgnA = pos[1];
            sgnB = pos[1] ^ pos[0];
         end
         stepper_seq_pkg::MODE_HALF: begin
            // Even positions single phase, odd both phases.
            sgnA = (pos >= 6'h03) && (pos <= 6'h05);
            sgnB = (pos >= 6'h05);
            magA = (pos == 6'h02 || pos == 6'h06) ? 12'h000 : stepper_seq_pkg::UNITY;
            magB = (pos == 6'h00 || pos == 6'h04) ? 12'h000 : stepper_seq_pkg::UNITY;
            if (!pos[0]) begin
               magA = (magA == 12'h000) ? 12'h000 : stepper_seq_pkg::SQRT2_Q10;
               magB = (magB == 12'h000) ? 12'h000 : stepper_seq_pkg::SQRT2_Q10;
            end
         end
         default: begin
            // Ministep: map index to 40 per cycle, sine on A, cosine on B.
            angle = (stepMode == stepper_seq_pkg::MODE_MINI25) ? {pos[4:0], 1'b0} : pos;
            quad  = (angle >= 6'h1E) ? 2'h3 : (angle >= 6'h14) ? 2'h2 : (angle >= 6'h0A) ? 2'h1 : 2'h0;
            qpos  = angle - 6'(quad) * 6'h0A;
            magA  = quad[0] ? sine_q(4'(6'h0A - qpos)) : sine_q(qpos[3:0]);
            magB  = quad[0] ? sine_q(qpos[3:0]) : sine_q(4'(6'h0A - qpos));
            sgnA  = quad[1];
            sgnB  = (quad == 2'h1) || (quad == 2'h2);
         end
      endcase
      // Current_input_a and high_speed_current_scaling gains, unity otherwise.
      gain = boostIn ? stepper_seq_pkg::CURRENT_INPUT_A_Q10 : stepper_seq_pkg::UNITY;
      prodA = (25'(magA) * 25'(gain)) >> 10;
      prodB = (25'(magB) * 25'(gain)) >> 10;
      if (fast && stepMode == stepper_seq_pkg::MODE_FULL) begin
         prodA = (25'(prodA[12:0]) * 25'(stepper_seq_pkg::OVD_Q10)) >> 10;
         prodB = (25'(prodB[12:0]) * 25'(stepper_seq_pkg::OVD_Q10)) >> 10;
      end
      next_magA  = disIn ? 13'h0000 : prodA[12:0];
      next_magB  = disIn ? 13'h0000 : prodB[12:0];
      next_chopSync = (next_chopCnt == 16'h0000);
      next_brakeOn  = brkIn && !rstIn && !disIn && !faultActive;
   end
   // Output registers.
   always_ff @(posedge clk) begin
      if (srst) begin
         phaseASign <= 1'b0;
         phaseBSign <= 1'b0;
         phaseAMag  <= 13'h0000;
         phaseBMag  <= 13'h0000;
         chopSync   <= 1'b0;
         brakeOn    <= 1'b0;
      end else begin
         phaseASign <= sgnA;
         phaseBSign <= sgnB;
         phaseAMag  <= next_magA;
         phaseBMag  <= next_magB;
         chopSync   <= next_chopSync;
         brakeOn    <= next_brakeOn;
      end
   end
   // Brake stays off one cycle after any blocking condition.
   a_brake_block: assert property (@(posedge clk) disable iff (srst)
      (faultActive || disIn || rstIn) |=> !brakeOn) else $error("brake on while blocked");
   a_disable_off: assert property (@(posedge clk) disable iff (srst)
      disIn |=> (phaseAMag == 13'h0000 && phaseBMag == 13'h0000)) else $error("current not off");
   a_step_runs: assert property (@(posedge clk) disable iff (srst)
      stepEvt |=> running) else $error("step did not enter run");
   a_pos_wrap: assert property (@(posedge clk) disable iff (srst)
      stepEvt |=> (pos < cycle_len(stepMode))) else $error("position out of cycle");
   a_full_both: assert property (@(posedge clk) disable iff (srst)
      (stepMode == stepper_seq_pkg::MODE_FULL && !disIn) |=> (phaseAMag != 13'h0000 && phaseBMag != 13'h0000))
      else $error("full step phase idle");
   a_chop_period: assert property (@(posedge clk) disable iff (srst)
      (chopCnt == 16'(stepper_seq_pkg::CHOP_CYCLES - 1)) |=> (chopCnt == 16'h0000)) else $error("chop wrap");
   a_brake_follow: assert property (@(posedge clk) disable iff (srst)
      (brkIn && !rstIn && !disIn && !faultActive) |=> brakeOn) else $error("brake not released");
   a_current_input_a_level: assert property (@(posedge clk) disable iff (srst)
      (boostIn && !disIn && stepMode == stepper_seq_pkg::MODE_HALF && pos[0]) |=> (phaseAMag == 13'h0533))
      else $error("current_input_a level wrong");

endmodule

//--- rtl/stepper_seq_pkg.sv
// Package of constants and types for the stepper phase current sequencer.
package stepper_seq_pkg;

   // Clock period in picoseconds (200 MHz).
   localparam int CLK_PERIOD_PS = 5000;

   // Chopper rate in Hz and its period in clock cycles.
   localparam int CHOP_FREQ_HZ = 20000;
   localparam int CHOP_CYCLES  = 1000000000 / (CHOP_FREQ_HZ / 1000) / CLK_PERIOD_PS;

   // Least step pulse width in ns, rounded up to cycles.
   localparam int STEP_MIN_NS     = 5000;
   localparam int STEP_MIN_CYCLES = (STEP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Idle time before running clears, in ms, as cycles.
   localparam int IDLE_MS     = 40;
   localparam int IDLE_CYCLES = IDLE_MS * (1000000000 / CLK_PERIOD_PS);

   // High_speed_current_scaling threshold: step period below 1 kHz period, in cycles.
   localparam int OVD_FREQ_HZ    = 1000;
   localparam int OVD_PERIOD_CYC = (1000000000 / OVD_FREQ_HZ) / CLK_PERIOD_PS * 1000;

   // Full scale of the current command (unity = 1024).
   localparam logic [11:0] UNITY       = 12'h400;
   // Torque compensation factor sqrt(2) scaled by 1024.
   localparam logic [11:0] SQRT2_Q10   = 12'h5A8;
   // Current_input_a factor 1.3 scaled by 1024.
   localparam logic [11:0] CURRENT_INPUT_A_Q10   = 12'h533;
   // High_speed_current_scaling factor 1.4 scaled by 1024.
   localparam logic [11:0] OVD_Q10     = 12'h59A;

   // Electrical cycle lengths per mode.
   localparam logic [5:0] FULL_POS  = 6'h04;
   localparam logic [5:0] HALF_POS  = 6'h08;
   localparam logic [5:0] MINI5_POS = 6'h28;
   localparam logic [5:0] MINI25_POS = 6'h14;

   // Polarity switch values 8 and above select inverted logic.
   localparam logic [3:0] POL_INV_MIN = 4'h8;

   // Step mode selection.
   typedef enum logic [1:0] {
      MODE_FULL   = 2'h0,
      MODE_HALF   = 2'h1,
      MODE_MINI25 = 2'h3,
      MODE_MINI5  = 2'h2
   } step_mode_type;

   // Step pulse qualifier states, Gray coded.
   typedef enum logic [1:0] {
      PULSE_IDLE = 2'h0,
      PULSE_HIGH = 2'h1,
      PULSE_DONE = 2'h3
   } pulse_state_type;

endpackage

//--- verif/motion_ctrl_model.sv
// Motion controller model that issues step pulses and the direction level.
`timescale 1ns/10ps
module motion_ctrl_model (
   // Clock shared with the block.
   input  wire logic clk,
   // Step and direction lines, 1 = optocoupler conducts.
   output logic      stepPin,
   output logic      dirPin
);
   // Both lines start inactive.
   initial begin
      stepPin = 1'b0;
      dirPin  = 1'b0;
   end

   // Issues one pulse of the given width; a direction change keeps the hold and setup margins.
   task automatic pulse(input logic dir, input int width);
      if (dir !== dirPin) begin
         repeat (800) @(negedge clk);
         dirPin = dir;
         repeat (200) @(negedge clk);
      end
      @(negedge clk);
      stepPin = 1'b1;
      repeat (width) @(negedge clk);
      stepPin = 1'b0;
      // A short low gap lets the synchroniser see the falling edge.
      repeat (8) @(negedge clk);
   endtask
endmodule

//--- verif/stepper_phase_current_sequencer_tb_top.sv
// Self-checking testbench for the stepper phase current sequencer.
`timescale 1ns/10ps
module stepper_phase_current_sequencer_tb_top;
   // Shortened idle limit keeps the run brief.
   localparam int IdleLimit = 2000;
   logic        clk                 = 1'b0;
   logic        srst                = 1'b1;
   logic        stepPin;
   logic        dirPin;
   logic        boostPin            = 1'b0;
   logic        disablePin          = 1'b0;
   logic        resetPin            = 1'b0;
   logic        brakePin            = 1'b0;
   logic [3:0]  inputPolaritySwitch = 4'h0;
   logic [1:0]  stepMode            = 2'h0;
   logic        faultActive         = 1'b0;
   logic        phaseASign;
   logic [12:0] phaseAMag;
   logic        phaseBSign;
   logic [12:0] phaseBMag;
   logic        chopSync;
   logic        running;
   logic        brakeOn;
   int          mismatches          = 0;
   int          nChecks             = 0;
   // Expected half step magnitudes and full step signs per position.
   logic [12:0] halfA [1:4]         = '{13'h400, 13'h000, 13'h400, 13'h5A8};
   logic [12:0] halfB [1:4]         = '{13'h400, 13'h5A8, 13'h400, 13'h000};
   logic [1:0]  fullSigns [2:4]     = '{2'h3, 2'h2, 2'h0};

   // Clock of 5 ns period.
   always #2.5 clk = ~clk;

   stepper_phase_current_sequencer #(.IDLE_LIMIT(IdleLimit)) dut (
      .clk(clk), .srst(srst), .stepPin(stepPin), .dirPin(dirPin), .boostPin(boostPin),
      .disablePin(disablePin), .resetPin(resetPin), .brakePin(brakePin),
      .inputPolaritySwitch(inputPolaritySwitch), .stepMode(stepMode), .faultActive(faultActive),
      .phaseASign(phaseASign), .phaseAMag(phaseAMag), .phaseBSign(phaseBSign), .phaseBMag(phaseBMag),
      .chopSync(chopSync), .running(running), .brakeOn(brakeOn));

   motion_ctrl_model ctl (.clk(clk), .stepPin(stepPin), .dirPin(dirPin));

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compares one value and reports a difference at once.
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      nChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Resets the block for 5 cycles in the given mode; all outputs must be low meanwhile.
   task automatic restart(input logic [1:0] mode);
      @(negedge clk);
      stepMode = mode;
      srst = 1'b1;
      repeat (5) @(negedge clk);
      chk("outputs in reset", 13'h0, phaseAMag | phaseBMag | {8'h00, phaseASign, phaseBSign, chopSync, running, brakeOn});
      srst = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   // Full step: short pulse refused, chopper rate, idle fall-back, high_speed_current_scaling, sign order and reversal.
   task automatic full_steps;
      int cnt;
      restart(stepper_seq_pkg::MODE_FULL);
      ctl.pulse(1'b0, 900);
      chk("running after short pulse", 13'h0, {12'h000, running});
      ctl.pulse(1'b0, 1010);
      chk("running after step", 13'h1, {12'h000, running});
      chk("full signs", 13'h1, {11'h000, phaseASign, phaseBSign});
      chk("full both energised", 13'h1, {12'h000, (|phaseAMag) & (|phaseBMag)});
      cnt = 0;
      repeat (10010) begin
         @(negedge clk);
         cnt += chopSync;
      end
      chk("chop pulses", 13'h1, 13'(cnt));
      chk("running after idle", 13'h0, {12'h000, running});
      for (int k = 2; k <= 4; k++) begin
         ctl.pulse(1'b0, 1010);
         chk("full signs", {11'h000, fullSigns[k]}, {11'h000, phaseASign, phaseBSign});
         chk("high_speed_current_scaling A", 13'h59A, phaseAMag);
         chk("high_speed_current_scaling B", 13'h59A, phaseBMag);
      end
      ctl.pulse(1'b1, 1010);
      chk("reverse signs", 13'h2, {11'h000, phaseASign, phaseBSign});
   endtask

   // Half step table, current_input_a on and off, brake release and its three blockers.
   task automatic half_steps;
      restart(stepper_seq_pkg::MODE_HALF);
      for (int k = 1; k <= 4; k++) begin
         ctl.pulse(1'b0, 1010);
         chk("half A", halfA[k], phaseAMag);
         chk("half B", halfB[k], phaseBMag);
      end
      ctl.pulse(1'b1, 1010);
      boostPin = 1'b1;
      repeat (10) @(negedge clk);
      chk("current_input_a A", 13'h533, phaseAMag);
      boostPin = 1'b0;
      brakePin = 1'b1;
      repeat (10) @(negedge clk);
      chk("current_input_a off A", 13'h400, phaseAMag);
      chk("brake released", 13'h1, {12'h000, brakeOn});
      for (int i = 0; i < 3; i++) begin
         {faultActive, resetPin, disablePin} = 3'(1 << i);
         repeat (10) @(negedge clk);
         chk("brake blocked", 13'h0, {12'h000, brakeOn});
         if (i == 0) begin
            chk("disabled A", 13'h0, phaseAMag);
         end
      end
      {faultActive, resetPin, disablePin} = 3'h0;
      brakePin = 1'b0;
   endtask

   // Ministep: quarter cycle leaves phase B dead, a full cycle of n steps wraps.
   task automatic mini(input logic [1:0] mode, input int n);
      logic [12:0] firstA;
      logic [12:0] firstB;
      restart(mode);
      for (int k = 1; k <= n + 1; k++) begin
         ctl.pulse(1'b0, 1010);
         if (k == 1) begin
            firstA = phaseAMag;
            firstB = phaseBMag;
         end
         if (k == n / 4) begin
            chk("mini B at quarter", 13'h0, phaseBMag);
            chk("mini A at quarter", 13'h400, phaseAMag);
         end
      end
      chk("mini A after wrap", firstA, phaseAMag);
      chk("mini B after wrap", firstB, phaseBMag);
   endtask

   // Switch settings below 8 keep positive logic, 8 and above invert every pin.
   task automatic polarity;
      logic [3:0] sw [3] = '{4'h7, 4'h8, 4'hF};
      {disablePin, resetPin, brakePin} = 3'h6;
      for (int i = 0; i < 3; i++) begin
         inputPolaritySwitch = sw[i];
         repeat (10) @(negedge clk);
         chk("brake under polarity", {12'h000, sw[i][3]}, {12'h000, brakeOn});
      end
   endtask

   // Main sequence.
   initial begin
      full_steps();
      half_steps();
      mini(stepper_seq_pkg::MODE_MINI5, 40);
      mini(stepper_seq_pkg::MODE_MINI25, 20);
      polarity();
      finish_test();
   end

   // Cuts a hang short.
   initial begin
      repeat (98000) @(posedge clk);
      mismatches++;
      $display("mismatch run length expected end seen timeout");
      finish_test();
   end
endmodule
